// >>> logic/ptd_defines.svh
// timing figures, key codes and tone dividers of the dial sequencer
`ifndef PTD_DEFINES_SVH
`define PTD_DEFINES_SVH

// clock rates in kHz
`define PTD_CLK_KHZ        125000
`define PTD_REF_KHZ        560

// times in ms
`define PTD_HOOK_ON_MS     300
`define PTD_DEBOUNCE_MS    14
`define PTD_BREAK_LONG_MS  67
`define PTD_MAKE_SHORT_MS  33
`define PTD_BREAK_SHORT_MS 60
`define PTD_MAKE_LONG_MS   40
`define PTD_IDP_SHORT_MS   500
`define PTD_IDP_LONG_MS    800
`define PTD_TONE_ON_MS     100
`define PTD_TONE_OFF_MS    100

// key codes
`define PTD_KEY_STAR       4'hA
`define PTD_KEY_HASH       4'hB
`define PTD_KEY_FLASH      4'hC
`define PTD_KEY_REDIAL     4'hD
`define PTD_KEY_NONE       4'hF
`define PTD_KEY_MAX_DIGIT  4'h9
`define PTD_ZERO_BREAKS    4'hA

// redial store
`define PTD_STORE_DEPTH    32

// tone half periods in 560 kHz reference ticks
`define PTD_HALF_R1        9'h192
`define PTD_HALF_R2        9'h16C
`define PTD_HALF_R3        9'h149
`define PTD_HALF_R4        9'h12A
`define PTD_HALF_C1        9'h0E8
`define PTD_HALF_C2        9'h0D2
`define PTD_HALF_C3        9'h0BE

`endif

// >>> logic/ptd_pkg.sv
// types shared by the dial sequencer files
package ptd_pkg;

  // wiring of the mode-select strap
  typedef enum logic [2:0] {
    PTD_STRAP_VSS  = 3'h0,
    PTD_STRAP_COL1 = 3'h1,
    PTD_STRAP_COL2 = 3'h2,
    PTD_STRAP_COL3 = 3'h3,
    PTD_STRAP_TONE = 3'h4
  } ptd_strap_t;

  // dialling configuration taken at off-hook
  typedef struct packed {
    logic toneMode;
    logic idpLong;
    logic ratio32;
  } ptd_cfg_t;

  // decoded keypad contact
  typedef struct packed {
    logic       valid;
    logic [1:0] row;
    logic [1:0] col;
  } ptd_key_t;

endpackage

// >>> logic/ptd_hook_qualify.sv
// hook input synchroniser and on-hook qualifier
`timescale 1ns/100ps
`default_nettype none
`include "ptd_defines.svh"

module ptd_hook_qualify #(
  parameter int HOOK_CYC = `PTD_HOOK_ON_MS * `PTD_CLK_KHZ
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // hook pin, high when off-hook
  input  wire logic hookRaw,
  // qualified on-hook state
  output logic      onHook
);

  localparam int CW = $clog2(HOOK_CYC + 1);

  logic          hookMeta;
  logic          hookSync;
  logic [CW-1:0] lowCount;
  logic [CW-1:0] next_lowCount;
  logic          next_onHook;

  // low time counter; short exchange drops never reach the limit
  always_comb begin
    next_lowCount = lowCount;
    next_onHook   = onHook;
    if (hookSync) begin
      next_lowCount = '0;
      next_onHook   = 1'b0;
    end else if (lowCount == CW'(HOOK_CYC)) begin
      next_onHook = 1'b1;
    end else begin
      next_lowCount = lowCount + 1'b1;
    end
  end

  // power-up assumes on-hook until the pin shows off-hook
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hookMeta <= 1'b0;
      hookSync <= 1'b0;
      lowCount <= '0;
      onHook   <= 1'b1;
    end else begin
      hookMeta <= hookRaw;
      hookSync <= hookMeta;
      lowCount <= next_lowCount;
      onHook   <= next_onHook;
    end
  end

endmodule

`default_nettype wire

// >>> logic/ptd_tone_synth.sv
// row and column square tones divided from a 560 kHz reference
`timescale 1ns/100ps
`default_nettype none
`include "ptd_defines.svh"

module ptd_tone_synth #(
  parameter int REF_DIV = `PTD_CLK_KHZ / `PTD_REF_KHZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // tone request
  input  wire logic       toneOn,
  input  wire logic [1:0] rowSel,
  input  wire logic [1:0] colSel,
  // bit 0 row tone, bit 1 column tone
  output logic [1:0]      toneOut
);

  localparam int RW = $clog2(REF_DIV + 1);

  logic [RW-1:0] refCount;
  logic [RW-1:0] next_refCount;
  logic          refTick;

  // half period per group and index; the fourth column gets the third column's half period
  function automatic logic [8:0] halfPeriod(input logic isCol, input logic [1:0] idx);
    unique case ({isCol, idx})
      3'h0:    halfPeriod = `PTD_HALF_R1;
      3'h1:    halfPeriod = `PTD_HALF_R2;
      3'h2:    halfPeriod = `PTD_HALF_R3;
      3'h3:    halfPeriod = `PTD_HALF_R4;
      3'h4:    halfPeriod = `PTD_HALF_C1;
      3'h5:    halfPeriod = `PTD_HALF_C2;
      default: halfPeriod = `PTD_HALF_C3;
    endcase
  endfunction

  // reference prescaler, stopped between bursts to save current
  assign refTick = (refCount == '0);
  always_comb begin
    next_refCount = '0;
    if (toneOn) begin
      next_refCount = refTick ? RW'(REF_DIV - 1) : refCount - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refCount <= '0;
    end else begin
      refCount <= next_refCount;
    end
  end

  // one divider per tone group; reference error scales both alike
  for (genvar g = 0; g < 2; g++) begin : gen_group
    logic [8:0] divCount;
    logic [8:0] next_divCount;
    logic       next_out;
    logic [1:0] sel;

    assign sel = (g == 0) ? rowSel : colSel;

    always_comb begin
      next_divCount = divCount;
      next_out      = toneOut[g];
      if (!toneOn) begin
        next_divCount = '0;
        next_out      = 1'b0;
      end else if (refTick) begin
        if (divCount == '0) begin
          next_divCount = halfPeriod(1'(g), sel) - 1'b1;
          next_out      = ~toneOut[g];
        end else begin
          next_divCount = divCount - 1'b1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        divCount   <= '0;
        toneOut[g] <= 1'b0;
      end else begin
        divCount   <= next_divCount;
        toneOut[g] <= next_out;
      end
    end
  end

endmodule

`default_nettype wire

// >>> logic/ptd_dial_sequencer.sv
// pulse and tone dial sequencer with hook qualification and redial store
// What this block does
// - on-hook stops dialling, keeps store only
// - on-hook after hook low over 300 ms
// - hook drops under 200 ms are ignored
// - mask low at once while hook low
// - reset clears the redial store
// - mask low through pulses and pauses
// - line pulse low breaks, high makes, pauses
// - line pulse rests low when not dialling
// - break lasts 60 or 67 ms
// - make lasts 40 or 33 ms
// - interdigit pause 500 or 800 ms
// - pause before train, one make after
// - mute high from key through tone
// - tone 100 ms on, 100 ms off
// - tones divided from 560 kHz reference
// - keys taken off-hook after 14 ms hold
// - ten pulses per second every option
// - strap sets mode, pause, ratio at off-hook
// - first star or hash switches to tone
`timescale 1ns/100ps
`default_nettype none
`include "ptd_defines.svh"

module ptd_dial_sequencer #(
  parameter int HOOK_CYC        = `PTD_HOOK_ON_MS * `PTD_CLK_KHZ,
  parameter int DEBOUNCE_CYC    = `PTD_DEBOUNCE_MS * `PTD_CLK_KHZ,
  parameter int BREAK_LONG_CYC  = `PTD_BREAK_LONG_MS * `PTD_CLK_KHZ,
  parameter int MAKE_SHORT_CYC  = `PTD_MAKE_SHORT_MS * `PTD_CLK_KHZ,
  parameter int BREAK_SHORT_CYC = `PTD_BREAK_SHORT_MS * `PTD_CLK_KHZ,
  parameter int MAKE_LONG_CYC   = `PTD_MAKE_LONG_MS * `PTD_CLK_KHZ,
  parameter int IDP_SHORT_CYC   = `PTD_IDP_SHORT_MS * `PTD_CLK_KHZ,
  parameter int IDP_LONG_CYC    = `PTD_IDP_LONG_MS * `PTD_CLK_KHZ,
  parameter int TONE_ON_CYC     = `PTD_TONE_ON_MS * `PTD_CLK_KHZ,
  parameter int TONE_OFF_CYC    = `PTD_TONE_OFF_MS * `PTD_CLK_KHZ
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // hook and strap pins
  input  wire logic                hookSenseIn,
  input  wire ptd_pkg::ptd_strap_t selectStrap,
  // single contact keypad, active low
  input  wire logic [3:0]          keyRowN,
  input  wire logic [3:0]          keyColN,
  // line and speech circuit
  output logic                     speechMask,
  output logic                     lineLoopPulse,
  output logic                     muteOut,
  output logic                     toneRowOut,
  output logic                     toneColOut,
  // status
  output logic                     dialModeTone,
  output logic [5:0]               storedDigits
);

  localparam int TW = $clog2(IDP_LONG_CYC + 1);
  localparam int DW = $clog2(DEBOUNCE_CYC + 1);

  typedef enum logic [7:0] {
    ST_OFFLINE  = 8'h01,
    ST_IDLE     = 8'h02,
    ST_PREPAUSE = 8'h04,
    ST_BREAK    = 8'h08,
    ST_MAKE     = 8'h10,
    ST_POSTMAKE = 8'h20,
    ST_TONE_ON  = 8'h40,
    ST_TONE_OFF = 8'h80
  } ptd_state_t;

  // synchronised pins
  logic [3:0]          rowMeta, rowSync, colMeta, colSync;
  ptd_pkg::ptd_strap_t strapMeta, strapSync;

  // qualified hook
  logic onHook;

  // keypad debounce
  ptd_pkg::ptd_key_t keyNow, keyPrev, next_keyPrev;
  logic [DW-1:0]     keyCount, next_keyCount;
  logic              keyTaken, next_keyTaken;
  logic              keyStrobe;
  logic [3:0]        keyCodeNow;
  logic [2:0]        rowIdx, colIdx;

  // sequencer state
  ptd_state_t        state, next_state;
  logic [TW-1:0]     timer, next_timer;
  logic [3:0]        breaksLeft, next_breaksLeft;
  ptd_pkg::ptd_cfg_t cfg, next_cfg, strapCfg;
  logic [1:0]        toneRow, next_toneRow, toneCol, next_toneCol;
  logic              toneOn, next_toneOn;
  logic              maskReg, next_maskReg;
  logic              next_linePulse, next_mute;

  // redial store
  logic [3:0] store [`PTD_STORE_DEPTH];
  logic [3:0] next_store [`PTD_STORE_DEPTH];
  logic [5:0] next_storedDigits;
  logic       newCall, next_newCall;

  // index of the single low line, or invalid
  function automatic logic [2:0] lowIndex(input logic [3:0] linesN);
    unique case (linesN)
      4'hE:    lowIndex = 3'h4;
      4'hD:    lowIndex = 3'h5;
      4'hB:    lowIndex = 3'h6;
      4'h7:    lowIndex = 3'h7;
      default: lowIndex = 3'h0;
    endcase
  endfunction

  // keypad position to key code
  function automatic logic [3:0] keyCode(input logic [1:0] row, input logic [1:0] col);
    if (col == 2'h3) begin
      keyCode = (row == 2'h0) ? `PTD_KEY_FLASH :
                (row == 2'h1) ? `PTD_KEY_REDIAL : `PTD_KEY_NONE;
    end else if (row == 2'h3) begin
      keyCode = (col == 2'h0) ? `PTD_KEY_STAR :
                (col == 2'h1) ? 4'h0 : `PTD_KEY_HASH;
    end else begin
      keyCode = 4'(row * 3 + col + 1);
    end
  endfunction

  // strap decode
  function automatic ptd_pkg::ptd_cfg_t strapDecode(input ptd_pkg::ptd_strap_t s);
    strapDecode = '0;
    unique case (s)
      ptd_pkg::PTD_STRAP_VSS:  strapDecode.idpLong = 1'b1;
      ptd_pkg::PTD_STRAP_COL1: strapDecode.idpLong = 1'b0;
      ptd_pkg::PTD_STRAP_COL2: strapDecode.ratio32 = 1'b1;
      ptd_pkg::PTD_STRAP_COL3: strapDecode = '{toneMode: 1'b0, idpLong: 1'b1, ratio32: 1'b1};
      ptd_pkg::PTD_STRAP_TONE: strapDecode.toneMode = 1'b1;
      default:                 strapDecode = '0;
    endcase
  endfunction

  // pin synchronisers; nothing reads the first stage but the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rowMeta   <= 4'hF;
      rowSync   <= 4'hF;
      colMeta   <= 4'hF;
      colSync   <= 4'hF;
      strapMeta <= ptd_pkg::PTD_STRAP_VSS;
      strapSync <= ptd_pkg::PTD_STRAP_VSS;
    end else begin
      rowMeta   <= keyRowN;
      rowSync   <= rowMeta;
      colMeta   <= keyColN;
      colSync   <= colMeta;
      strapMeta <= selectStrap;
      strapSync <= strapMeta;
    end
  end

  ptd_hook_qualify #(
    .HOOK_CYC (HOOK_CYC)
  ) u_hook (
    .clk     (clk),
    .reset_n (reset_n),
    .hookRaw (hookSenseIn),
    .onHook  (onHook)
  );

  // key decode
  always_comb begin
    rowIdx       = lowIndex(rowSync);
    colIdx       = lowIndex(colSync);
    keyNow       = {rowIdx[2] & colIdx[2], rowIdx[1:0], colIdx[1:0]};
    keyCodeNow   = keyCode(keyPrev.row, keyPrev.col);
    strapCfg     = strapDecode(strapSync);
  end

  // debounce: one strobe per press, held off-hook for the full time
  always_comb begin
    next_keyPrev  = keyNow;
    next_keyCount = '0;
    next_keyTaken = 1'b0;
    keyStrobe     = 1'b0;
    if (!onHook && keyNow.valid && keyNow == keyPrev) begin
      next_keyTaken = keyTaken;
      next_keyCount = keyCount;
      if (keyCount != DW'(DEBOUNCE_CYC)) begin
        next_keyCount = keyCount + 1'b1;
      end else if (!keyTaken) begin
        keyStrobe     = 1'b1;
        next_keyTaken = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      keyPrev  <= '0;
      keyCount <= '0;
      keyTaken <= 1'b0;
    end else begin
      keyPrev  <= next_keyPrev;
      keyCount <= next_keyCount;
      keyTaken <= next_keyTaken;
    end
  end

  // dialling sequencer; keys arriving mid-digit are dropped
  always_comb begin
    next_state        = state;
    next_timer        = (timer != '0) ? timer - 1'b1 : timer;
    next_breaksLeft   = breaksLeft;
    next_cfg          = cfg;
    next_toneRow      = toneRow;
    next_toneCol      = toneCol;
    next_newCall      = newCall;
    next_store        = store;
    next_storedDigits = storedDigits;
    if (onHook) begin
      next_state   = ST_OFFLINE;
      next_timer   = '0;
      next_cfg     = strapCfg;
      next_newCall = 1'b1;
    end else begin
      unique case (state)
        ST_OFFLINE: next_state = ST_IDLE;
        ST_IDLE: begin
          if (keyStrobe) begin
            if (keyCodeNow == `PTD_KEY_FLASH) begin
              next_cfg = strapCfg; // flash returns to initial mode
            end else if (cfg.toneMode && keyCodeNow <= `PTD_KEY_HASH) begin
              next_state   = ST_TONE_ON;
              next_timer   = TW'(TONE_ON_CYC - 1);
              next_toneRow = keyPrev.row;
              next_toneCol = keyPrev.col;
            end else if (keyCodeNow == `PTD_KEY_STAR || keyCodeNow == `PTD_KEY_HASH) begin
              next_cfg.toneMode = 1'b1;
            end else if (keyCodeNow <= `PTD_KEY_MAX_DIGIT) begin
              next_state      = ST_PREPAUSE;
              next_timer      = cfg.idpLong ? TW'(IDP_LONG_CYC - 1)
                                            : TW'(IDP_SHORT_CYC - 1);
              next_breaksLeft = (keyCodeNow == 4'h0) ? `PTD_ZERO_BREAKS : keyCodeNow;
              // a new call overwrites the stored number from the start
              if (newCall) begin
                next_store[0]     = keyCodeNow;
                next_storedDigits = 6'h01;
                next_newCall      = 1'b0;
              end else if (storedDigits != 6'(`PTD_STORE_DEPTH)) begin
                next_store[storedDigits[4:0]] = keyCodeNow;
                next_storedDigits             = storedDigits + 1'b1;
              end
            end
          end
        end
        ST_PREPAUSE: begin
          if (timer == '0) begin
            next_state = ST_BREAK;
            next_timer = cfg.ratio32 ? TW'(BREAK_SHORT_CYC - 1)
                                     : TW'(BREAK_LONG_CYC - 1);
          end
        end
        ST_BREAK: begin
          if (timer == '0) begin
            next_breaksLeft = breaksLeft - 1'b1;
            next_state      = (breaksLeft == 4'h1) ? ST_POSTMAKE : ST_MAKE;
            next_timer      = cfg.ratio32 ? TW'(MAKE_LONG_CYC - 1)
                                          : TW'(MAKE_SHORT_CYC - 1);
          end
        end
        ST_MAKE: begin
          if (timer == '0) begin
            next_state = ST_BREAK;
            next_timer = cfg.ratio32 ? TW'(BREAK_SHORT_CYC - 1)
                                     : TW'(BREAK_LONG_CYC - 1);
          end
        end
        ST_POSTMAKE: begin
          if (timer == '0) begin
            next_state = ST_IDLE;
          end
        end
        ST_TONE_ON: begin
          if (timer == '0) begin
            next_state = ST_TONE_OFF;
            next_timer = TW'(TONE_OFF_CYC - 1);
          end
        end
        ST_TONE_OFF: begin
          if (timer == '0) begin
            next_state = ST_IDLE;
          end
        end
      endcase
    end
  end

  // outputs follow the next state so each changes with it
  always_comb begin
    next_linePulse = next_state inside {ST_PREPAUSE, ST_MAKE, ST_POSTMAKE};
    next_maskReg   = next_state inside {ST_IDLE, ST_TONE_ON, ST_TONE_OFF};
    next_mute      = next_state inside {ST_TONE_ON, ST_TONE_OFF};
    next_toneOn    = (next_state == ST_TONE_ON);
  end

  // the store is only cleared here, never by the hook
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state         <= ST_OFFLINE;
      timer         <= '0;
      breaksLeft    <= '0;
      cfg           <= '0;
      toneRow       <= '0;
      toneCol       <= '0;
      toneOn        <= 1'b0;
      newCall       <= 1'b1;
      maskReg       <= 1'b0;
      lineLoopPulse <= 1'b0;
      muteOut       <= 1'b0;
      dialModeTone  <= 1'b0;
      storedDigits  <= '0;
      for (int i = 0; i < `PTD_STORE_DEPTH; i++) begin
        store[i] <= '0;
      end
    end else begin
      state         <= next_state;
      timer         <= next_timer;
      breaksLeft    <= next_breaksLeft;
      cfg           <= next_cfg;
      toneRow       <= next_toneRow;
      toneCol       <= next_toneCol;
      toneOn        <= next_toneOn;
      newCall       <= next_newCall;
      maskReg       <= next_maskReg;
      lineLoopPulse <= next_linePulse;
      muteOut       <= next_mute;
      dialModeTone  <= next_cfg.toneMode;
      storedDigits  <= next_storedDigits;
      store         <= next_store;
    end
  end

  // the raw pin gates the mask so a drop opens the speech path at once
  assign speechMask = maskReg & hookSenseIn;

  ptd_tone_synth u_tone (
    .clk     (clk),
    .reset_n (reset_n),
    .toneOn  (toneOn),
    .rowSel  (toneRow),
    .colSel  (toneCol),
    .toneOut ({toneColOut, toneRowOut})
  );

endmodule

`default_nettype wire

// >>> verification/ptd_dial_sequencer_sva.sv
// port assertions of the dial sequencer
`timescale 1ns/100ps
`default_nettype none
module ptd_dial_sequencer_sva #(
  parameter int HOOK_CYC        = 300,
  parameter int BREAK_LONG_CYC  = 67,
  parameter int MAKE_SHORT_CYC  = 33,
  parameter int BREAK_SHORT_CYC = 60,
  parameter int MAKE_LONG_CYC   = 40,
  parameter int IDP_SHORT_CYC   = 500,
  parameter int IDP_LONG_CYC    = 800,
  parameter int TONE_ON_CYC     = 100,
  parameter int TONE_OFF_CYC    = 100
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // watched pins
  input wire logic       hookSenseIn,
  input wire logic       speechMask,
  input wire logic       lineLoopPulse,
  input wire logic       muteOut,
  input wire logic       toneRowOut,
  input wire logic       toneColOut,
  input wire logic       dialModeTone,
  input wire logic [5:0] storedDigits
);
  logic [11:0] highRun, lowRun, muteRun, hookLow;

  // saturate so a long rest never wraps into a legal figure
  function automatic logic [11:0] inc(input logic [11:0] x);
    return (x == 12'hFFF) ? x : x + 12'h001;
  endfunction

  // run lengths of each level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      highRun <= 12'h000;
      lowRun  <= 12'h000;
      muteRun <= 12'h000;
      hookLow <= 12'h000;
    end else begin
      highRun <= lineLoopPulse ? inc(highRun) : 12'h000;
      lowRun  <= lineLoopPulse ? 12'h000 : inc(lowRun);
      muteRun <= muteOut ? inc(muteRun) : 12'h000;
      hookLow <= hookSenseIn ? 12'h000 : inc(hookLow);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // rise in a train ends a break; rise from rest opens a pause
  sequence brkEnd;
    $rose(lineLoopPulse) && !$past(speechMask);
  endsequence
  sequence highEnd;
    $fell(lineLoopPulse) && hookSenseIn;
  endsequence

  mask_hook_a: assert property (!hookSenseIn |-> !speechMask)
    else $error("mask high on hook low");
  mask_dial_a: assert property (lineLoopPulse |-> !speechMask)
    else $error("mask high in pulsing");
  break_len_a: assert property (brkEnd |->
    (lowRun == BREAK_LONG_CYC || lowRun == BREAK_SHORT_CYC))
    else $error("break length wrong");
  make_len_a: assert property (highEnd |-> (highRun == MAKE_SHORT_CYC ||
    highRun == MAKE_LONG_CYC || highRun == IDP_SHORT_CYC || highRun == IDP_LONG_CYC))
    else $error("make length wrong");
  mute_span_a: assert property ($fell(muteOut) && hookSenseIn |->
    muteRun == TONE_ON_CYC + TONE_OFF_CYC)
    else $error("mute span wrong");
  tone_quiet_a: assert property (!muteOut |-> !toneRowOut && !toneColOut)
    else $error("tone without mute");
  onhook_idle_a: assert property (hookLow > HOOK_CYC + 8 |->
    !lineLoopPulse && !muteOut)
    else $error("busy on-hook");
  glitch_keep_a: assert property ($rose(hookSenseIn) && hookLow < 12'h0C8 |->
    $stable(dialModeTone))
    else $error("short drop changed mode");
  reset_clear_a: assert property ($rose(reset_n) |->
    storedDigits == 6'h00 && !lineLoopPulse && !muteOut)
    else $error("reset left outputs set");
endmodule
`default_nettype wire

// >>> verification/ptd_line_model.sv
// line and handset model: cradle contact and exchange break counter
`timescale 1ns/100ps
`default_nettype none
module ptd_line_model (
  // clock
  input  wire logic  clk,
  // cradle command from the bench
  input  wire logic  offHookCmd,
  // device line side
  input  wire logic  lineLoopPulse,
  input  wire logic  speechMask,
  // hook contact and counted breaks
  output logic       hookSenseIn,
  output logic [3:0] breakCnt
);
  logic loopPrev = 1'b0, maskPrev = 1'b0;

  // bounce-free contact; the bench makes any bounce
  assign hookSenseIn = offHookCmd;

  // exchange counts loop restores; a rise from rest starts a digit
  always_ff @(posedge clk) begin
    loopPrev <= lineLoopPulse;
    maskPrev <= speechMask;
    if (lineLoopPulse && !loopPrev) begin
      breakCnt <= maskPrev ? 4'h0 : breakCnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/ptd_dial_sequencer_tb_top.sv
// self-checking bench of the dial sequencer
`timescale 1ns/100ps
`default_nettype none
module ptd_dial_sequencer_tb_top;
  localparam int HOOK = 300, DEB = 14, BL = 67, MS = 33, BS = 60, ML = 40, IS = 500,
    IL = 800, TON = 100, TOFF = 100;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       offHookCmd = 1'b0;
  logic       hookSenseIn;
  logic [2:0] selectStrap = ptd_pkg::PTD_STRAP_COL1;
  logic [3:0] keyRowN = 4'hF;
  logic [3:0] keyColN = 4'hF;
  logic       speechMask;
  logic       lineLoopPulse;
  logic       muteOut;
  logic       toneRowOut;
  logic       toneColOut;
  logic       dialModeTone;
  logic [5:0] storedDigits;
  logic [3:0] breakCnt;
  int         error_cnt = 0;
  int         comparisons = 0;
  int         cycles = 0;

  ptd_dial_sequencer #(.HOOK_CYC(HOOK), .DEBOUNCE_CYC(DEB), .BREAK_LONG_CYC(BL),
    .MAKE_SHORT_CYC(MS), .BREAK_SHORT_CYC(BS), .MAKE_LONG_CYC(ML), .IDP_SHORT_CYC(IS),
    .IDP_LONG_CYC(IL), .TONE_ON_CYC(TON), .TONE_OFF_CYC(TOFF)) ptd_dial_sequencer_inst (
    .clk(clk), .reset_n(reset_n), .hookSenseIn(hookSenseIn), .keyRowN(keyRowN),
    .selectStrap(ptd_pkg::ptd_strap_t'(selectStrap)), .keyColN(keyColN), .speechMask(speechMask),
    .lineLoopPulse(lineLoopPulse), .muteOut(muteOut), .toneRowOut(toneRowOut),
    .toneColOut(toneColOut), .dialModeTone(dialModeTone), .storedDigits(storedDigits));

  ptd_line_model ptd_line_model_inst (.clk(clk), .offHookCmd(offHookCmd),
    .lineLoopPulse(lineLoopPulse), .speechMask(speechMask), .hookSenseIn(hookSenseIn),
    .breakCnt(breakCnt));

  always #4 clk = ~clk;

  // hang guard, well above the longest run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // negedges at one level; 0 line pulse, 1 mute
  task automatic span(input int k, input logic lvl, output int n);
    n = 0;
    while ((k ? muteOut : lineLoopPulse) === lvl && n < 3000) begin
      n++;
      @(negedge clk);
    end
  endtask

  // hold past the debounce, then release
  task automatic press(input int r, input int c);
    @(posedge clk);
    keyRowN <= ~(4'h1 << r);
    keyColN <= ~(4'h1 << c);
    cyc(40);
    keyRowN <= 4'hF;
    keyColN <= 4'hF;
    cyc(5);
  endtask

  // strap is taken on-hook, so set it before lifting
  task automatic new_call(input ptd_pkg::ptd_strap_t s);
    @(posedge clk);
    offHookCmd <= 1'b0;
    cyc(HOOK + 20);
    selectStrap <= s;
    cyc(5);
    offHookCmd <= 1'b1;
    cyc(10);
  endtask

  task automatic dial_pulse(input int r, c, nb, interdigit_pause, brk, mk);
    int n;
    fork
      press(r, c);
      begin
        @(negedge clk);
        span(0, 1'b0, n);
        check("mask in pause", speechMask, 1'b0);
        span(0, 1'b1, n);
        check("pause", n, interdigit_pause);
        for (int i = 0; i < nb; i++) begin
          span(0, 1'b0, n);
          check("break", n, brk);
          span(0, 1'b1, n);
          check("make", n, mk);
        end
      end
    join
    @(negedge clk);
    check("breaks seen", breakCnt, nb);
    check("rest level", lineLoopPulse, 1'b0);
    check("mask after", speechMask, 1'b1);
  endtask

  task automatic tone_key(input int r, input int c);
    int n;
    fork
      press(r, c);
      begin
        @(negedge clk);
        span(1, 1'b0, n);
        @(negedge clk);
        check("tones on", {toneRowOut, toneColOut}, 2'h3);
        span(1, 1'b1, n);
        check("mute span", n + 1, TON + TOFF);
      end
    join
    check("tones quiet", {toneRowOut, toneColOut, lineLoopPulse}, 3'h0);
  endtask

  task automatic t_reset();
    @(negedge clk);
    check("store after reset", storedDigits, 6'h00);
    check("line at rest", lineLoopPulse, 1'b0);
  endtask

  // every pulse strap; one and ten breaks among the digits
  task automatic t_straps();
    int rw [4] = '{0, 0, 3, 2};
    int cl [4] = '{0, 1, 1, 2};
    int nb [4] = '{1, 2, 10, 9};
    int ip [4] = '{IL, IS, IS, IL};
    for (int k = 0; k < 4; k++) begin
      new_call(ptd_pkg::ptd_strap_t'(k));
      check("mode at lift", dialModeTone, 1'b0);
      dial_pulse(rw[k], cl[k], nb[k], ip[k], k < 2 ? BL : BS, k < 2 ? MS : ML);
    end
  endtask

  // star switches mode, short drop keeps the call, flash restores
  task automatic t_switch();
    new_call(ptd_pkg::PTD_STRAP_COL1);
    press(3, 0);
    @(negedge clk);
    check("star mode", dialModeTone, 1'b1);
    check("star silent", {lineLoopPulse, muteOut}, 2'h0);
    @(posedge clk);
    offHookCmd <= 1'b0;
    for (int i = 0; i < 150; i++) begin
      @(negedge clk);
      if (i % 50 == 0) check("mask on drop", speechMask, 1'b0);
    end
    @(posedge clk);
    offHookCmd <= 1'b1;
    cyc(10);
    @(negedge clk);
    check("call kept", dialModeTone, 1'b1);
    tone_key(1, 1);
    press(0, 3);
    @(negedge clk);
    check("flash mode", dialModeTone, 1'b0);
    new_call(ptd_pkg::PTD_STRAP_TONE);
    check("tone strap", dialModeTone, 1'b1);
    tone_key(2, 1);
  endtask

  // store kept, on-hook keys dropped, on-hook aborts a digit in its pause
  task automatic t_onhook();
    new_call(ptd_pkg::PTD_STRAP_COL3);
    dial_pulse(0, 2, 3, IL, BS, ML);
    @(posedge clk);
    offHookCmd <= 1'b0;
    cyc(HOOK + 20);
    press(1, 1);
    offHookCmd <= 1'b1;
    cyc(200);
    @(negedge clk);
    check("store kept", storedDigits, 6'h01);
    check("on-hook key", {lineLoopPulse, muteOut}, 2'h0);
    press(1, 1);
    cyc(100);
    offHookCmd <= 1'b0;
    cyc(HOOK + 20);
    @(negedge clk);
    check("aborted", {lineLoopPulse, muteOut}, 2'h0);
  endtask

  initial begin
    cyc(10);
    reset_n <= 1'b1;
    t_reset();
    t_straps();
    t_switch();
    t_onhook();
    tally_and_finish();
  end
endmodule

bind ptd_dial_sequencer ptd_dial_sequencer_sva #(.HOOK_CYC(HOOK_CYC),
  .BREAK_LONG_CYC(BREAK_LONG_CYC), .MAKE_SHORT_CYC(MAKE_SHORT_CYC),
  .BREAK_SHORT_CYC(BREAK_SHORT_CYC), .MAKE_LONG_CYC(MAKE_LONG_CYC),
  .IDP_SHORT_CYC(IDP_SHORT_CYC), .IDP_LONG_CYC(IDP_LONG_CYC),
  .TONE_ON_CYC(TONE_ON_CYC), .TONE_OFF_CYC(TONE_OFF_CYC)) ptd_dial_sequencer_sva_inst (
  .clk(clk), .reset_n(reset_n), .hookSenseIn(hookSenseIn), .speechMask(speechMask),
  .lineLoopPulse(lineLoopPulse), .muteOut(muteOut), .toneRowOut(toneRowOut),
  .toneColOut(toneColOut), .dialModeTone(dialModeTone), .storedDigits(storedDigits));
`default_nettype wire
